/* File: rtl/nvs_cfg.svh */
// Constants for the nonvolatile memory sequencer: keys, address map and timing.
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH
`define NVS_KEY_FIRST 8'h55
`define NVS_KEY_SECOND 8'hAA
`define NVS_PF_LAST 15'h07FF
`define NVS_UID_LAST 15'h0003
`define NVS_RSVD_ADDR 15'h0004
`define NVS_REV_ADDR 15'h0005
`define NVS_DEV_ADDR 15'h0006
`define NVS_CFG_FIRST 15'h0007
`define NVS_CFG_LAST 15'h000A
`define NVS_EE_BASE 15'h7000
`define NVS_EE_LAST 15'h70FF
`define NVS_ROW_MASK 15'h7FE0
`define NVS_EE_TIME_US 20
`define NVS_EE_CYCLES (`NVS_EE_TIME_US * 50)
`define NVS_ER_TIME_US 40
`define NVS_ER_CYCLES (`NVS_ER_TIME_US * 50)
`define NVS_REV_VALUE 14'h0001
`define NVS_DEV_VALUE 14'h0123
`define NVS_BLANK 14'h3FFF
`endif

/* File: rtl/nvs_pkg.sv */
// Types shared by the nonvolatile memory sequencer.
`default_nettype none
package nvs_pkg;
  typedef enum logic [1:0] {nvs_idle, nvs_key1, nvs_key2} nvs_unlock_t;
  typedef enum logic [1:0] {nvs_ready, nvs_ee_busy, nvs_er_busy} nvs_op_t;
  typedef struct packed {
    logic modify_permit_bit;
    logic space_select_bit;
    logic erase_select;
    logic done_irq_enable;
  } nvs_ctrl_t;
endpackage
`default_nettype wire

/* File: rtl/nvs_sequencer.sv */
// Unlock, EEPROM write, row erase and register read sequencer for nonvolatile memory.
`timescale 1ns/100ps
`default_nettype none
`include "nvs_cfg.svh"

// Behaviour
// - Arm only after unlock key 55h, then AAh, then write-start set.
// - One EEPROM word per write with an implicit erase.
// - EEPROM write runs without stall; clears start, sets done, may interrupt.
// - Clearing write-start during an EEPROM write has no effect.
// - Program flash writes never erase automatically.
// - Program flash erase acts on a whole 32-word row only.
// - Write-protected row: clear write-start and skip the erase.
// - Row erase stalls the CPU; completion sets done and may interrupt.
// - Erase keeps write latches; permit bit stays unchanged.
// - Space set: 0000h-0003h user ID read and write; the code reads and erases there but ignores a plain write start.
// - Read stalls briefly, data next cycle, read-start self clears.
// - Code protection blocks write and read starts; word loads and key writes still go through.
module nvs_sequencer
  import nvs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire nvs_ctrl_t ctrl,
  input wire logic [14:0] nvm_addr,
  input wire logic [13:0] nvm_word_in,
  input wire logic word_load,
  input wire logic key_write,
  input wire logic [7:0] key_value,
  input wire logic start_set,
  input wire logic start_clear,
  input wire logic read_set,
  input wire logic code_protect,
  input wire logic row_protect,
  input wire logic [13:0] cfg_word,
  input wire logic [13:0] flash_rdata,
  input wire logic [7:0] ee_rdata,
  output logic write_start,
  output logic read_start,
  output logic nvm_done_flag,
  output logic nvm_irq,
  output logic cpu_stall,
  output logic [13:0] nvm_word_pair,
  output logic ee_we,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  output logic row_erase,
  output logic uid_erase,
  output logic [14:0] row_addr,
  output logic [14:0] rd_addr,
  output logic rd_space
);
  localparam logic [15:0] EE_CYC = 16'(`NVS_EE_CYCLES);
  localparam logic [15:0] ER_CYC = 16'(`NVS_ER_CYCLES);

  logic rst_meta, rst_sync;
  nvs_unlock_t key_st, next_key_st;
  nvs_op_t op_st, next_op_st;
  logic [15:0] cnt, next_cnt;
  logic next_write_start, next_read_start, next_done, next_irq, next_stall;
  logic [13:0] next_word;
  logic next_ee_we, next_row_erase, next_uid_erase;
  logic [7:0] next_ee_addr, next_ee_wdata;
  logic [14:0] next_row_addr;
  logic rd_pending, next_rd_pending;
  logic is_ee, is_uid, is_pf, armed;

  // Reset release through two flip-flops; only the second is used.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Address decode of the writable spaces.
  always_comb begin
    is_pf = !ctrl.space_select_bit && nvm_addr <= `NVS_PF_LAST;
    is_uid = ctrl.space_select_bit && nvm_addr <= `NVS_UID_LAST;
    is_ee = ctrl.space_select_bit && nvm_addr >= `NVS_EE_BASE
      && nvm_addr <= `NVS_EE_LAST;
    armed = start_set && key_st == nvs_key2 && ctrl.modify_permit_bit
      && op_st == nvs_ready && !code_protect;
  end

  // Unlock, operation and read sequencing next-state logic.
  always_comb begin
    next_key_st = key_st;
    next_op_st = op_st;
    next_cnt = cnt;
    next_write_start = write_start;
    next_read_start = 1'b0;
    next_done = nvm_done_flag;
    next_stall = 1'b0;
    next_word = nvm_word_pair;
    next_ee_we = 1'b0;
    next_ee_addr = ee_addr;
    next_ee_wdata = ee_wdata;
    next_row_erase = 1'b0;
    next_uid_erase = 1'b0;
    next_row_addr = row_addr;
    next_rd_pending = 1'b0;
    if (word_load) begin
      next_word = nvm_word_in;
    end
    // Key tracking: any wrong key or a start or read request resets the sequence.
    if (key_write) begin
      if (key_value == `NVS_KEY_FIRST) begin
        next_key_st = nvs_key1;
      end else if (key_value == `NVS_KEY_SECOND && key_st == nvs_key1) begin
        next_key_st = nvs_key2;
      end else begin
        next_key_st = nvs_idle;
      end
    end else if (start_set || read_set) begin
      next_key_st = nvs_idle;
    end
    case (op_st)
      nvs_ready: begin
        if (armed && is_ee) begin
          next_op_st = nvs_ee_busy;
          next_write_start = 1'b1;
          next_ee_addr = nvm_addr[7:0];
          next_ee_wdata = nvm_word_pair[7:0];
          next_cnt = EE_CYC;
        // Only a request with erase select set ever erases; a plain write never does.
        end else if (armed && ctrl.erase_select && (is_pf || is_uid)) begin
          if (is_pf && row_protect) begin
            next_write_start = 1'b0;
          end else begin
            next_op_st = nvs_er_busy;
            next_write_start = 1'b1;
            next_row_addr = nvm_addr & `NVS_ROW_MASK;
            next_cnt = ER_CYC;
            next_stall = 1'b1;
          end
        end else if (read_set && !code_protect) begin
          next_read_start = 1'b1;
          next_stall = 1'b1;
          next_rd_pending = 1'b1;
        end
      end
      nvs_ee_busy: begin
        // Software clears are not looked at here, so the write finishes.
        next_ee_we = cnt == EE_CYC;
        if (cnt == 16'h0001) begin
          next_op_st = nvs_ready;
          next_write_start = 1'b0;
          next_done = 1'b1;
        end
        next_cnt = cnt - 16'h0001;
      end
      nvs_er_busy: begin
        next_stall = 1'b1;
        next_row_erase = cnt == ER_CYC && !ctrl.space_select_bit;
        next_uid_erase = cnt == ER_CYC && ctrl.space_select_bit;
        if (cnt == 16'h0001) begin
          next_op_st = nvs_ready;
          next_write_start = 1'b0;
          next_stall = 1'b0;
          next_done = 1'b1;
        end
        next_cnt = cnt - 16'h0001;
      end
      default: next_op_st = nvs_ready;
    endcase
    // A start taken in this cycle wins over a software clear of write-start.
    if (start_clear && op_st == nvs_ready && next_op_st == nvs_ready) begin
      next_write_start = 1'b0;
    end
    // Read data lands in the word pair one cycle after the request.
    if (rd_pending) begin
      if (!rd_space) begin
        next_word = flash_rdata;
      end else if (rd_addr <= `NVS_UID_LAST) begin
        next_word = flash_rdata;
      end else if (rd_addr == `NVS_REV_ADDR) begin
        next_word = `NVS_REV_VALUE;
      end else if (rd_addr == `NVS_DEV_ADDR) begin
        next_word = `NVS_DEV_VALUE;
      end else if (rd_addr >= `NVS_CFG_FIRST && rd_addr <= `NVS_CFG_LAST) begin
        next_word = cfg_word;
      end else if (rd_addr >= `NVS_EE_BASE && rd_addr <= `NVS_EE_LAST) begin
        next_word = {6'h00, ee_rdata};
      end else begin
        next_word = 14'h0000;
      end
    end
    // The interrupt follows the done flag while its enable is set.
    next_irq = next_done && ctrl.done_irq_enable;
  end

  // State registers.
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      key_st <= nvs_idle;
      op_st <= nvs_ready;
      cnt <= 16'h0000;
      write_start <= 1'b0;
      read_start <= 1'b0;
      nvm_done_flag <= 1'b0;
      nvm_irq <= 1'b0;
      cpu_stall <= 1'b0;
      nvm_word_pair <= 14'h0000;
      ee_we <= 1'b0;
      ee_addr <= 8'h00;
      ee_wdata <= 8'h00;
      row_erase <= 1'b0;
      uid_erase <= 1'b0;
      row_addr <= 15'h0000;
      rd_addr <= 15'h0000;
      rd_space <= 1'b0;
      rd_pending <= 1'b0;
    end else begin
      key_st <= next_key_st;
      op_st <= next_op_st;
      cnt <= next_cnt;
      write_start <= next_write_start;
      read_start <= next_read_start;
      nvm_done_flag <= next_done;
      nvm_irq <= next_irq;
      cpu_stall <= next_stall;
      nvm_word_pair <= next_word;
      ee_we <= next_ee_we;
      ee_addr <= next_ee_addr;
      ee_wdata <= next_ee_wdata;
      row_erase <= next_row_erase;
      uid_erase <= next_uid_erase;
      row_addr <= next_row_addr;
      rd_addr <= nvm_addr;
      rd_space <= ctrl.space_select_bit;
      rd_pending <= next_rd_pending;
    end
  end

  // Checks on sequencing.
  sequence s_unlock;
    key_st == nvs_key2 ##0 start_set && ctrl.modify_permit_bit && !code_protect
      && op_st == nvs_ready && is_ee;
  endsequence
  a_ee_start: assert property (@(posedge clock) disable iff (!rst_sync)
    s_unlock |=> op_st == nvs_ee_busy && write_start) else $error("EEPROM start missed");
  a_no_permit: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_ready && !ctrl.modify_permit_bit |=> op_st == nvs_ready)
    else $error("Operation started without permit");
  a_protect_blk: assert property (@(posedge clock) disable iff (!rst_sync)
    code_protect && op_st == nvs_ready |=> op_st == nvs_ready && !read_start)
    else $error("Access under code protection");
  a_bad_key: assert property (@(posedge clock) disable iff (!rst_sync)
    key_write && key_value != `NVS_KEY_FIRST && key_value != `NVS_KEY_SECOND
      |=> key_st == nvs_idle) else $error("Wrong key kept sequence");
  a_ee_hold: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_ee_busy && cnt > 16'h0001 |=> write_start)
    else $error("EEPROM write aborted");
  a_ee_done: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_ee_busy && cnt == 16'h0001 |=> !write_start && nvm_done_flag && !cpu_stall)
    else $error("EEPROM completion wrong");
  a_erase_stall: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_er_busy && cnt > 16'h0001 |=> cpu_stall) else $error("Erase without stall");
  a_erase_done: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_er_busy && cnt == 16'h0001 |=> !write_start && nvm_done_flag && !cpu_stall)
    else $error("Erase completion wrong");
  a_no_auto_erase: assert property (@(posedge clock) disable iff (!rst_sync)
    op_st == nvs_ready && !ctrl.erase_select |=> op_st != nvs_er_busy)
    else $error("Erase started without erase select");
  a_wp_skip: assert property (@(posedge clock) disable iff (!rst_sync)
    armed && ctrl.erase_select && is_pf && row_protect && !is_ee
      |=> op_st == nvs_ready && !write_start) else $error("Protected row erased");
  a_read_next: assert property (@(posedge clock) disable iff (!rst_sync)
    read_start |=> !read_start && !cpu_stall) else $error("Read start not cleared");
endmodule
`default_nettype wire

/* File: bench/nvs_array_model.sv */
// Behavioural model of the flash and EEPROM arrays behind the sequencer.
`timescale 1ns/100ps
`default_nettype none
module nvs_array_model (
  input wire logic clock,
  input wire logic [14:0] rd_addr,
  input wire logic ee_we,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_wdata,
  output logic [13:0] flash_rdata,
  output logic [7:0] ee_rdata,
  output logic [13:0] cfg_word
);
  logic [7:0] ee_mem [256];
  // EEPROM cells start blank and take one byte per write strobe.
  initial for (int i = 0; i < 256; i++) ee_mem[i] = 8'hFF;
  always @(posedge clock) if (ee_we) ee_mem[ee_addr] <= ee_wdata;
  // Read data follows the registered read address with no delay.
  assign flash_rdata = rd_addr[13:0] ^ 14'h2A5A;
  assign ee_rdata = ee_mem[rd_addr[7:0]];
  assign cfg_word = 14'h1000 | rd_addr[13:0];
endmodule
`default_nettype wire

/* File: bench/nvs_sequencer_bench.sv */
// Self-checking bench for the nonvolatile memory sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_sequencer_bench;
  import nvs_pkg::*;
  logic clock = 0, rstn = 0, word_load = 0, key_write = 0, start_set = 0, start_clear = 0;
  logic read_set = 0, code_protect = 0, row_protect = 0;
  nvs_ctrl_t ctrl = '0;
  logic [14:0] nvm_addr = '0, row_addr, rd_addr, a;
  logic [13:0] nvm_word_in = '0, cfg_word, flash_rdata, nvm_word_pair;
  logic [7:0] key_value = '0, ee_rdata, ee_addr, ee_wdata, d;
  logic write_start, read_start, nvm_done_flag, nvm_irq, cpu_stall, ee_we, row_erase;
  logic uid_erase, rd_space;
  int fails = 0, total_checks = 0, seed = 75, ee_cnt = 0, er_cnt = 0, ud_cnt = 0;
  nvs_sequencer nvs_sequencer_inst (.clock, .rstn, .ctrl, .nvm_addr, .nvm_word_in, .word_load,
    .key_write, .key_value, .start_set, .start_clear, .read_set, .code_protect, .row_protect,
    .cfg_word, .flash_rdata, .ee_rdata, .write_start, .read_start, .nvm_done_flag, .nvm_irq,
    .cpu_stall, .nvm_word_pair, .ee_we, .ee_addr, .ee_wdata, .row_erase, .uid_erase, .row_addr,
    .rd_addr, .rd_space);
  nvs_array_model nvs_array_model_inst (.clock, .rd_addr, .ee_we, .ee_addr, .ee_wdata,
    .flash_rdata, .ee_rdata, .cfg_word);
  // Free-running 50 MHz clock.
  always #10 clock = ~clock;
  // Counts the array strobes so that refused starts can be seen to do nothing.
  always @(posedge clock) begin
    ee_cnt += ee_we;
    er_cnt += row_erase;
    ud_cnt += uid_erase;
  end
  // Inputs change a fixed 2 ns after each rising edge.
  task automatic tick(int n = 1);
    repeat (n) begin
      @(posedge clock);
      #2;
    end
  endtask
  task automatic check(logic [14:0] exp, logic [14:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Two key writes on back-to-back cycles, then the start request, with no other
  // request in between, as software does with interrupts masked.
  task automatic unlock(logic [7:0] k1, logic [7:0] k2);
    key_write = 1;
    key_value = k1;
    tick();
    key_value = k2;
    tick();
    key_write = 0;
    start_set = 1;
    tick();
    start_set = 0;
  endtask
  task automatic wait_idle(int lim);
    while ((write_start === 1'b1 || cpu_stall === 1'b1) && lim > 0) begin
      tick();
      lim--;
    end
    if (lim == 0) begin
      fails++;
      close_out();
    end
  endtask
  task automatic rd(logic sp, logic [14:0] ad, logic [13:0] exp);
    ctrl.space_select_bit = sp;
    nvm_addr = ad;
    read_set = 1;
    tick();
    read_set = 0;
    check(15'h0003, {13'h0000, read_start, cpu_stall});
    tick(3);
    check({1'b0, exp}, {1'b0, nvm_word_pair});
    check(15'h0000, {13'h0000, read_start, cpu_stall});
  endtask
  // Main sequence: writes, refused starts, erases and reads.
  initial begin
    tick(16);
    rstn = 1;
    tick(4);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'hFF : 8'($random(seed));
      a = {7'h70, d};
      ctrl = {3'b110, 1'(i)};
      nvm_addr = a;
      nvm_word_in = 14'($random(seed));
      word_load = 1;
      tick();
      word_load = 0;
      unlock(8'h55, 8'hAA);
      tick();
      check(15'h0001, {14'h0000, write_start});
      check({13'h0000, 1'(i), 1'b0}, {13'h0000, nvm_done_flag, cpu_stall});
      start_clear = 1;
      tick();
      start_clear = 0;
      check(15'h0001, {14'h0000, write_start});
      wait_idle(1100);
      tick(2);
      check({13'h0000, 1'b1, 1'(i)}, {13'h0000, nvm_done_flag, nvm_irq});
      check(15'(i + 1), 15'(ee_cnt));
      rd(1, a, {6'h00, nvm_word_in[7:0]});
    end
    for (int i = 0; i < 5; i++) begin
      ctrl = {1'(i != 2), 1'(i != 4), 2'b00};
      code_protect = (i == 3);
      if (i == 4) nvm_addr = 15'h0040;
      d = 8'($random(seed)) & 8'hFE;
      if (i == 0) unlock(d, 8'hAA);
      else if (i == 1) unlock(8'hAA, 8'h55);
      else unlock(8'h55, 8'hAA);
      tick(3);
      check(15'h0000, {14'h0000, write_start});
      check(15'h0002, 15'(ee_cnt));
      check(15'h0000, 15'(er_cnt));
      read_set = (i == 3);
      tick();
      read_set = 0;
      check(15'h0000, {13'h0000, read_start, cpu_stall});
    end
    code_protect = 0;
    for (int i = 0; i < 3; i++) begin
      a = 15'($random(seed)) & (i == 1 ? 15'h0003 : 15'h07FF);
      ctrl = {1'b1, 1'(i == 1), 2'b10};
      row_protect = (i == 2);
      nvm_addr = a;
      unlock(8'h55, 8'hAA);
      tick();
      check({14'h0000, 1'(i != 2)}, {14'h0000, cpu_stall});
      if (i != 2) check(a & 15'h7FE0, row_addr);
      wait_idle(2100);
    end
    row_protect = 0;
    check(15'h0001, 15'(er_cnt));
    check(15'h0001, 15'(ud_cnt));
    a = 15'($random(seed)) & 15'h07FF;
    rd(0, a, a[13:0] ^ 14'h2A5A);
    rd(0, 15'h07FF, 14'h07FF ^ 14'h2A5A);
    rd(1, 15'h0004, 14'h0000);
    rd(1, 15'h0005, `NVS_REV_VALUE);
    rd(1, 15'h0006, `NVS_DEV_VALUE);
    rd(1, 15'h000A, 14'h100A);
    close_out();
  end
endmodule
`default_nettype wire
